// ---- src/wdc_watchdog.sv ----
// Watchdog control register, timed change sequences and reset-cause flags
//
// Functional notes
// - Level 1 starts disabled; writing enable one turns it on freely.
// - Level 1 disable: write unlock+enable, then within four cycles write enable zero.
// - Level 2 keeps the watchdog running; enable always reads one.
// - Level 2 period change: unlock+enable, then period within four cycles, enable ignored.
// - Level 2 refuses disabling even after the full unlock sequence.
// - Hardware clears the unlock bit four cycles after it was set.
// - Enable may be written zero only while unlock is set.
// - Period bits change only while unlock is set.
// - Upper four bits of the reset-cause register read zero.
// - Watchdog reset flag set by watchdog reset, cleared by power-on or writing zero.
// - Brown-out flag set by brown-out reset, cleared by power-on or writing zero.
// - Pin reset flag set by pin reset, cleared by power-on or writing zero.
// - Power-on flag set by power-on, cleared only by writing zero.
// - Interrupt flag sets on time-out in interrupt mode; cleared by vector or writing one.
// - Interrupt requested only with flag, enable and global enable all set.
// - With enable and irq enable, time-out sets the flag and clears irq enable in the same cycle, so no interrupt is requested.
// - Enable/irq-enable pairs: stopped, interrupt, reset, flag first then reset.
// - Level 1 enable forced on while watchdog reset flag is set.
// - Period codes give 2048 to 1048576 oscillator cycles; upper codes reserved.
// - Control layout: flag, irq enable, period msb, unlock, enable, period low.
// - Counter advances on the 128 kHz watchdog oscillator.
// - Lock fuse selects level 1 (unprogrammed) or level 2 (programmed).
// - Count restarts on kick instruction, when disabled, and on chip reset.
// - Reset-mode time-out gives an internal reset pulse of one clock.
`timescale 1ns/1ps
`default_nettype none

module wdc_watchdog #(
    parameter int unsigned BASE_OSC_CYCLES = wdc_pkg::BASE_OSC_CYCLES_DEF
) (
    // Clock and power-on reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // I/O register port
    input  wire logic [5:0]  io_addr_i,
    input  wire logic        io_wr_i,
    input  wire logic        io_rd_i,
    input  wire logic [7:0]  io_wdata_i,
    output logic      [7:0]  io_rdata_o,
    // Core interface
    input  wire logic        dog_kick_instr_i,
    input  wire logic        global_irq_en_i,
    input  wire logic        irq_ack_i,
    output logic             dog_irq_o,
    // Reset system
    input  wire logic        chip_rst_i,
    input  wire logic        pin_reset_evt_i,
    input  wire logic        brownout_reset_evt_i,
    input  wire logic        dog_lock_fuse_i,
    output logic             dog_reset_o,
    // Watchdog oscillator, sampled level
    input  wire logic        dog_osc_i
);

    // Register state
    logic                          irq_flag_reg;
    logic                          irq_en_reg;
    logic                          enable_reg;
    logic [wdc_pkg::PERIOD_W-1:0]  period_reg;
    logic [2:0]                    unlock_cnt_reg;
    logic [wdc_pkg::CAUSE_USED_W-1:0] cause_reg;
    logic                          level2_reg;
    logic                          osc_prev_reg;
    logic [7:0]                    rdata_reg;

    // Decoded strobes and derived state
    logic                          ctrl_wr;
    logic                          cause_wr;
    logic                          unlock_open;
    logic                          unlock_start;
    logic                          enable_eff;
    logic                          run;
    logic                          osc_tick;
    logic                          timeout;
    logic                          tmo_irq;
    logic                          tmo_reset;
    logic [wdc_pkg::PERIOD_W-1:0]  wr_period;
    logic [7:0]                    ctrl_view;
    logic [7:0]                    cause_view;

    assign ctrl_wr  = io_wr_i && (io_addr_i == wdc_pkg::DOG_CONTROL_ADDR);
    assign cause_wr = io_wr_i && (io_addr_i == wdc_pkg::RESET_CAUSE_ADDR);

    assign wr_period = {io_wdata_i[wdc_pkg::CTRL_PERIOD_MSB],
                        io_wdata_i[wdc_pkg::CTRL_PERIOD_LO_HI:wdc_pkg::CTRL_PERIOD_LO_LO]};

    assign unlock_open  = (unlock_cnt_reg != wdc_pkg::UNLOCK_IDLE);
    // Both unlock and enable written one open the window
    assign unlock_start = ctrl_wr && io_wdata_i[wdc_pkg::CTRL_UNLOCK]
                          && io_wdata_i[wdc_pkg::CTRL_ENABLE];

    // Effective enable as seen by the counter and by reads
    assign enable_eff = level2_reg || enable_reg || cause_reg[wdc_pkg::CAUSE_DOG];

    assign run       = enable_eff || irq_en_reg;
    assign tmo_irq   = timeout && irq_en_reg;
    assign tmo_reset = timeout && !irq_en_reg && enable_eff;

    // The fuse is a strap: caught by a clocked process while the chip is held
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            level2_reg <= 1'b0;
        end
        else if (chip_rst_i)
        begin
            level2_reg <= dog_lock_fuse_i;
        end
    end

    // Inputs are synchronous to clk_i; a rising edge of the sampled
    // oscillator level becomes one tick. The oscillator must run well below
    // clk_i for every edge to be seen.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            osc_prev_reg <= 1'b0;
        end
        else
        begin
            osc_prev_reg <= dog_osc_i;
        end
    end

    assign osc_tick = dog_osc_i && !osc_prev_reg;

    wdc_period_cnt #(
        .BASE_OSC_CYCLES (BASE_OSC_CYCLES)
    ) u_period_cnt (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .tick_i    (osc_tick),
        .clear_i   (dog_kick_instr_i || chip_rst_i),
        .run_i     (run),
        .sel_i     (period_reg),
        .timeout_o (timeout)
    );

    // Unlock window counter; a fresh unlock write restarts the window
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            unlock_cnt_reg <= wdc_pkg::UNLOCK_IDLE;
        end
        else if (chip_rst_i)
        begin
            unlock_cnt_reg <= wdc_pkg::UNLOCK_IDLE;
        end
        else if (unlock_start)
        begin
            unlock_cnt_reg <= wdc_pkg::UNLOCK_CYCLES;
        end
        else if (ctrl_wr && unlock_open)
        begin
            // Second write of the sequence closes the window at once
            unlock_cnt_reg <= wdc_pkg::UNLOCK_IDLE;
        end
        else if (unlock_open)
        begin
            unlock_cnt_reg <= unlock_cnt_reg - wdc_pkg::UNLOCK_DONE;
        end
    end

    // Enable bit
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            enable_reg <= 1'b0;
        end
        else if (chip_rst_i)
        begin
            enable_reg <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            if (io_wdata_i[wdc_pkg::CTRL_ENABLE])
            begin
                enable_reg <= 1'b1;
            end
            else if (unlock_open && !level2_reg)
            begin
                // Level 2 ignores this entirely; enable_eff stays high anyway
                enable_reg <= 1'b0;
            end
        end
    end

    // Period select
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            period_reg <= wdc_pkg::PERIOD_RESET;
        end
        else if (chip_rst_i)
        begin
            period_reg <= wdc_pkg::PERIOD_RESET;
        end
        else if (ctrl_wr && unlock_open)
        begin
            period_reg <= wr_period;
        end
    end

    // Interrupt enable: software write wins over the hardware clear
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            irq_en_reg <= 1'b0;
        end
        else if (chip_rst_i)
        begin
            irq_en_reg <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            irq_en_reg <= io_wdata_i[wdc_pkg::CTRL_IRQ_EN];
        end
        else if (tmo_irq && enable_eff)
        begin
            irq_en_reg <= 1'b0;
        end
    end

    // Interrupt flag: a time-out in the clearing cycle keeps it set
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            irq_flag_reg <= 1'b0;
        end
        else if (chip_rst_i)
        begin
            irq_flag_reg <= 1'b0;
        end
        else if (tmo_irq)
        begin
            irq_flag_reg <= 1'b1;
        end
        else if (irq_ack_i || (ctrl_wr && io_wdata_i[wdc_pkg::CTRL_IRQ_FLAG]))
        begin
            irq_flag_reg <= 1'b0;
        end
    end

    assign dog_irq_o = irq_flag_reg && irq_en_reg && global_irq_en_i;

    // Internal reset pulse, exactly one clock per time-out
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            dog_reset_o <= 1'b0;
        end
        else
        begin
            dog_reset_o <= tmo_reset;
        end
    end

    // Reset-cause flags survive chip reset; only power-on (rst_i) reloads them.
    // Each bit: a set event wins over a software write of zero.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cause_reg <= wdc_pkg::CAUSE_POR_VALUE;
        end
        else
        begin
            if (tmo_reset)
            begin
                cause_reg[wdc_pkg::CAUSE_DOG] <= 1'b1;
            end
            else if (cause_wr && !io_wdata_i[wdc_pkg::CAUSE_DOG])
            begin
                cause_reg[wdc_pkg::CAUSE_DOG] <= 1'b0;
            end
            if (brownout_reset_evt_i)
            begin
                cause_reg[wdc_pkg::CAUSE_BROWNOUT] <= 1'b1;
            end
            else if (cause_wr && !io_wdata_i[wdc_pkg::CAUSE_BROWNOUT])
            begin
                cause_reg[wdc_pkg::CAUSE_BROWNOUT] <= 1'b0;
            end
            if (pin_reset_evt_i)
            begin
                cause_reg[wdc_pkg::CAUSE_PIN] <= 1'b1;
            end
            else if (cause_wr && !io_wdata_i[wdc_pkg::CAUSE_PIN])
            begin
                cause_reg[wdc_pkg::CAUSE_PIN] <= 1'b0;
            end
            if (cause_wr && !io_wdata_i[wdc_pkg::CAUSE_POWERON])
            begin
                cause_reg[wdc_pkg::CAUSE_POWERON] <= 1'b0;
            end
        end
    end

    // Read views
    assign ctrl_view = {irq_flag_reg,
                        irq_en_reg,
                        period_reg[wdc_pkg::PERIOD_W-1],
                        unlock_open,
                        enable_eff,
                        period_reg[wdc_pkg::PERIOD_W-2:0]};
    assign cause_view = {wdc_pkg::CAUSE_HI_ZERO, cause_reg};

    // Read data is registered; unmapped addresses read zero
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_reg <= 8'h00;
        end
        else if (io_rd_i)
        begin
            unique case (io_addr_i)
                wdc_pkg::DOG_CONTROL_ADDR: rdata_reg <= ctrl_view;
                wdc_pkg::RESET_CAUSE_ADDR: rdata_reg <= cause_view;
                default:                   rdata_reg <= 8'h00;
            endcase
        end
    end

    assign io_rdata_o = rdata_reg;

endmodule // wdc_watchdog

`default_nettype wire

// ---- src/wdc_pkg.sv ----
// Shared constants of the watchdog control and reset-cause block
package wdc_pkg;

    // I/O register map
    localparam logic [5:0]  DOG_CONTROL_ADDR    = 6'h21;
    localparam logic [5:0]  RESET_CAUSE_ADDR    = 6'h22;

    // Control register bit positions
    localparam int unsigned CTRL_IRQ_FLAG       = 7;
    localparam int unsigned CTRL_IRQ_EN         = 6;
    localparam int unsigned CTRL_PERIOD_MSB     = 5;
    localparam int unsigned CTRL_UNLOCK         = 4;
    localparam int unsigned CTRL_ENABLE         = 3;
    localparam int unsigned CTRL_PERIOD_LO_HI   = 2;
    localparam int unsigned CTRL_PERIOD_LO_LO   = 0;

    // Reset-cause register bit positions
    localparam int unsigned CAUSE_DOG           = 3;
    localparam int unsigned CAUSE_BROWNOUT      = 2;
    localparam int unsigned CAUSE_PIN           = 1;
    localparam int unsigned CAUSE_POWERON       = 0;
    localparam int unsigned CAUSE_USED_W        = 4;

    // Reset values
    localparam logic [3:0]  PERIOD_RESET        = 4'h0;
    localparam logic [3:0]  CAUSE_POR_VALUE     = 4'h1;
    localparam logic [3:0]  CAUSE_CLEAR         = 4'h0;
    localparam logic [3:0]  CAUSE_HI_ZERO       = 4'h0;

    // Period select
    localparam int unsigned PERIOD_W            = 4;
    localparam logic [3:0]  PERIOD_MAX_CODE     = 4'h9;
    localparam int unsigned BASE_OSC_CYCLES_DEF = 2048;
    localparam int unsigned OSC_FREQ_KHZ        = 128;
    localparam int unsigned DOG_CNT_W           = 21;

    // Timed unlock window, in system clock cycles
    localparam logic [2:0]  UNLOCK_CYCLES       = 3'h4;
    localparam logic [2:0]  UNLOCK_DONE         = 3'h1;
    localparam logic [2:0]  UNLOCK_IDLE         = 3'h0;

    // Length of the internal reset pulse, in system clock cycles
    localparam int unsigned DOG_RESET_CYCLES    = 1;

endpackage : wdc_pkg

// ---- src/wdc_period_cnt.sv ----
// Watchdog period counter driven by oscillator ticks
`timescale 1ns/1ps
`default_nettype none

module wdc_period_cnt #(
    parameter int unsigned BASE_OSC_CYCLES = wdc_pkg::BASE_OSC_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // Control
    input  wire logic                          tick_i,
    input  wire logic                          clear_i,
    input  wire logic                          run_i,
    input  wire logic [wdc_pkg::PERIOD_W-1:0]  sel_i,
    // Event
    output logic                               timeout_o
);

    logic [wdc_pkg::PERIOD_W-1:0]  sel_eff;
    logic [wdc_pkg::DOG_CNT_W-1:0] limit;
    logic [wdc_pkg::DOG_CNT_W-1:0] count_reg;
    logic [wdc_pkg::DOG_CNT_W-1:0] count_next;
    logic                          hit;

    // Reserved codes run at the longest period rather than an undefined one
    assign sel_eff = (sel_i > wdc_pkg::PERIOD_MAX_CODE) ? wdc_pkg::PERIOD_MAX_CODE : sel_i;
    assign limit   = wdc_pkg::DOG_CNT_W'(BASE_OSC_CYCLES) << sel_eff;
    assign hit     = run_i && tick_i && (count_reg == limit - 1'b1);

    always_comb
    begin
        count_next = count_reg;
        if (clear_i || !run_i || hit)
        begin
            count_next = '0;
        end
        else if (tick_i)
        begin
            count_next = count_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            count_reg <= '0;
        end
        else
        begin
            count_reg <= count_next;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            timeout_o <= 1'b0;
        end
        else
        begin
            timeout_o <= hit && !clear_i;
        end
    end

endmodule // wdc_period_cnt

`default_nettype wire

// ---- verif/wdc_watchdog_monitor.sv ----
// Port-level checker for the watchdog control block
`timescale 1ns/1ps
`default_nettype none

module wdc_watchdog_monitor (
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       rst_i,
    // Register port
    input wire logic [5:0] io_addr_i,
    input wire logic       io_wr_i,
    input wire logic       io_rd_i,
    input wire logic [7:0] io_wdata_i,
    input wire logic [7:0] io_rdata_o,
    // Core and reset system
    input wire logic       global_irq_en_i,
    input wire logic       dog_irq_o,
    input wire logic       chip_rst_i,
    input wire logic       dog_lock_fuse_i,
    input wire logic       dog_reset_o
);
    logic      lvl2_reg;
    logic      wdr_reg;
    logic      por_reg;
    wire logic rd_ctl = io_rd_i && io_addr_i == wdc_pkg::DOG_CONTROL_ADDR;
    wire logic rd_cau = io_rd_i && io_addr_i == wdc_pkg::RESET_CAUSE_ADDR;
    wire logic wr_cau = io_wr_i && io_addr_i == wdc_pkg::RESET_CAUSE_ADDR;

    // Fuse is only meaningful once a chip reset has captured it
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            lvl2_reg <= 1'b0;
        else if (chip_rst_i)
            lvl2_reg <= dog_lock_fuse_i;
    end

    // Conservative: any write to the cause register drops the expectation
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            wdr_reg <= 1'b0;
        else if (wr_cau)
            wdr_reg <= 1'b0;
        else if (dog_reset_o)
            wdr_reg <= 1'b1;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            por_reg <= 1'b1;
        else if (wr_cau && !io_wdata_i[0])
            por_reg <= 1'b0;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_unlock;
        io_wr_i && io_addr_i == wdc_pkg::DOG_CONTROL_ADDR && io_wdata_i[4] && io_wdata_i[3];
    endsequence

    sequence s_quiet_read;
        // Window spans the four edges after the unlock; a read on the fifth sees it shut
        (!io_wr_i && !chip_rst_i) [*4] ##1 rd_ctl;
    endsequence

    a_unlock_closes: assert property (s_unlock ##1 s_quiet_read |=> !io_rdata_o[4])
        else $error("unlock bit still set after its window");
    a_reset_one_cycle: assert property (dog_reset_o |=> !dog_reset_o)
        else $error("watchdog reset pulse longer than one cycle");
    a_irq_gated: assert property (!global_irq_en_i |-> !dog_irq_o)
        else $error("interrupt requested with global enable off");
    a_rdata_holds: assert property ($changed(io_rdata_o) |-> $past(io_rd_i) || $past(io_rd_i, 2))
        else $error("read data changed without a read");
    a_cause_upper_zero: assert property (rd_cau |=> io_rdata_o[7:4] == 4'h0)
        else $error("reserved cause bits read nonzero");
    a_level2_enable: assert property (rd_ctl && lvl2_reg && !chip_rst_i |=> io_rdata_o[3])
        else $error("enable read zero in level 2");
    a_dog_flag_kept: assert property (rd_cau && wdr_reg |=> io_rdata_o[3])
        else $error("watchdog reset flag lost");
    a_dog_forces_en: assert property (rd_ctl && wdr_reg && !chip_rst_i |=> io_rdata_o[3])
        else $error("enable read zero while watchdog reset flag set");
    a_poweron_kept: assert property (rd_cau && por_reg |=> io_rdata_o[0])
        else $error("power-on flag lost without a zero write");
endmodule // wdc_watchdog_monitor

bind wdc_watchdog wdc_watchdog_monitor mon_u (.clk_i, .rst_i, .io_addr_i, .io_wr_i, .io_rd_i,
    .io_wdata_i, .io_rdata_o, .global_irq_en_i, .dog_irq_o, .chip_rst_i, .dog_lock_fuse_i,
    .dog_reset_o);

`default_nettype wire

// ---- verif/wdc_watchdog_bench.sv ----
// Self-checking bench for the watchdog control block
`timescale 1ns/1ps
`default_nettype none

module wdc_watchdog_bench;
    localparam int unsigned BASE = 4;
    localparam logic [5:0]  CTL  = wdc_pkg::DOG_CONTROL_ADDR;
    localparam logic [5:0]  CAU  = wdc_pkg::RESET_CAUSE_ADDR;
    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic [5:0] addr  = 6'h00;
    logic       wr    = 1'b0;
    logic       rd    = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic       kick  = 1'b0;
    logic       gie   = 1'b0;
    logic       ack   = 1'b0;
    logic       chip  = 1'b0;
    logic       pin   = 1'b0;
    logic       bo    = 1'b0;
    logic       fuse  = 1'b0;
    logic       osc   = 1'b0;
    logic       irq;
    logic       dres;
    logic [5:0] ra;
    int         err_count = 0;
    int         cmp_count = 0;
    int         pulses    = 0;
    int         cyc       = 0;
    int         p0;

    wdc_watchdog #(.BASE_OSC_CYCLES(BASE)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .io_addr_i(addr), .io_wr_i(wr), .io_rd_i(rd), .io_wdata_i(wdata),
        .io_rdata_o(rdata), .dog_kick_instr_i(kick), .global_irq_en_i(gie),
        .irq_ack_i(ack), .dog_irq_o(irq), .chip_rst_i(chip), .pin_reset_evt_i(pin),
        .brownout_reset_evt_i(bo), .dog_lock_fuse_i(fuse), .dog_reset_o(dres),
        .dog_osc_i(osc));

    always #2 clk_i = ~clk_i;

    // Code 9 and a reserved code dominate, about 17k to 21k cycles in all
    always @(posedge clk_i)
    begin
        cyc++;
        if (dres === 1'b1)
            pulses++;
        if (cyc == 60000)
        begin
            err_count++;
            $display("MISMATCH t=%0t run hung", $time);
            close_out();
        end
    end

    function automatic logic [7:0] cv(logic f, logic ie, logic un, logic en, logic [3:0] p);
        return {f, ie, p[3], un, en, p[2:0]};
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic step(output logic s, input logic v);
        @(posedge clk_i);
        #1;
        s = v;
    endtask

    task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk_i);
        #1;
        wr = 1'b0;
    endtask

    task automatic rc(input logic [5:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        #1;
        addr = a;
        rd = 1'b1;
        @(posedge clk_i);
        #1;
        rd = 1'b0;
        @(posedge clk_i);
        #1;
        chk(rdata, exp);
    endtask

    // Oscillator runs at a quarter of the system clock at most
    task automatic ticks(input int n);
        repeat (n)
        begin
            step(osc, 1'b1);
            repeat (2) @(posedge clk_i);
            #1;
            osc = 1'b0;
            @(posedge clk_i);
        end
        repeat (6) @(posedge clk_i);
    endtask

    task automatic pulse_kick();
        step(kick, 1'b1);
        step(kick, 1'b0);
    endtask

    task automatic tmo(input logic [3:0] p, input bit kk);
        int n;
        // Reserved codes run at the longest period
        n = BASE << ((p > wdc_pkg::PERIOD_MAX_CODE) ? wdc_pkg::PERIOD_MAX_CODE : p);
        wr_reg(CTL, cv(0, 0, 1, 1, p));
        wr_reg(CTL, cv(0, 0, 0, 1, p));
        pulse_kick();
        p0 = pulses;
        if (kk)
        begin
            ticks(n - 1);
            pulse_kick();
        end
        ticks(n - 1);
        chk(8'(pulses - p0), 8'h00);
        ticks(1);
        chk(8'(pulses - p0), 8'h01);
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        void'($urandom(32'h90A4EFBB));
        repeat (4) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        step(chip, 1'b1);
        step(chip, 1'b0);
        rc(CAU, 8'h01);
        rc(CTL, 8'h00);
        repeat (4)
        begin
            ra = 6'($urandom_range(63, 0));
            if (ra == CTL || ra == CAU)
                ra = 6'h3F;
            rc(ra, 8'h00);
        end
        $display("reset values done");
        wr_reg(CTL, 8'h08);
        rc(CTL, 8'h08);
        wr_reg(CTL, 8'h27);
        rc(CTL, 8'h08);
        wr_reg(CTL, 8'h18);
        rc(CTL, 8'h18);
        wr_reg(CTL, 8'h21);
        rc(CTL, 8'h08);
        wr_reg(CTL, 8'h18);
        wr_reg(CTL, 8'h21);
        rc(CTL, 8'h21);
        wr_reg(CTL, 8'h39);
        repeat (3) @(posedge clk_i);
        rc(CTL, 8'h29);
        wr_reg(CTL, 8'h00);
        rc(CTL, 8'h29);
        $display("level one sequences done");
        tmo(4'h0, 1'b1);
        tmo(4'($urandom_range(7, 0)), 1'b0);
        tmo(4'($urandom_range(7, 0)), 1'b0);
        tmo(4'hF, 1'b0);
        tmo(4'h9, 1'b0);
        rc(CAU, 8'h09);
        wr_reg(CTL, 8'h18);
        wr_reg(CTL, 8'h00);
        rc(CTL, 8'h08);
        wr_reg(CAU, 8'h07);
        rc(CAU, 8'h01);
        wr_reg(CTL, 8'h18);
        wr_reg(CTL, 8'h00);
        rc(CTL, 8'h00);
        $display("reset mode timing done");
        gie = 1'b1;
        wr_reg(CTL, 8'h40);
        pulse_kick();
        p0 = pulses;
        ticks(BASE);
        chk({7'h00, irq}, 8'h01);
        rc(CTL, 8'hC0);
        gie = 1'b0;
        @(posedge clk_i);
        chk({7'h00, irq}, 8'h00);
        #1;
        gie = 1'b1;
        wr_reg(CTL, 8'hC0);
        rc(CTL, 8'h40);
        ticks(BASE);
        step(ack, 1'b1);
        step(ack, 1'b0);
        rc(CTL, 8'h40);
        chk(8'(pulses - p0), 8'h00);
        wr_reg(CTL, 8'h48);
        pulse_kick();
        ticks(BASE);
        rc(CTL, 8'h88);
        chk(8'(pulses - p0), 8'h00);
        ticks(BASE);
        chk(8'(pulses - p0), 8'h01);
        $display("interrupt modes done");
        step(pin, 1'b1);
        step(pin, 1'b0);
        step(bo, 1'b1);
        step(bo, 1'b0);
        rc(CAU, 8'h0F);
        wr_reg(CAU, 8'h00);
        rc(CAU, 8'h00);
        $display("reset cause done");
        fuse = 1'b1;
        step(chip, 1'b1);
        step(chip, 1'b0);
        rc(CTL, 8'h08);
        wr_reg(CTL, 8'h18);
        wr_reg(CTL, 8'h00);
        rc(CTL, 8'h08);
        wr_reg(CTL, 8'h18);
        wr_reg(CTL, 8'h05);
        rc(CTL, 8'h0D);
        wr_reg(CTL, 8'h0F);
        rc(CTL, 8'h0D);
        $display("level two done");
        close_out();
    end
endmodule // wdc_watchdog_bench

`default_nettype wire
